/* File: common/prdi_pkg.sv */
`default_nettype none
package prdi_pkg;
	// register index per control byte and for the status word; byte address is four times it
	localparam logic [11:0] IDX_CTRL2 = 12'h9c9;
	localparam logic [11:0] IDX_CTRL1 = 12'h9ca;
	localparam logic [11:0] IDX_CTRL0 = 12'h9cb;
	localparam logic [11:0] IDX_STATUS = 12'h9cc;
	// wishbone widths
	localparam int unsigned ADR_W = 14;
	localparam int unsigned DAT_W = 32;
	localparam int unsigned SEL_W = 4;
	// field layout inside a control byte
	localparam int unsigned CODE_W = 3;
	localparam int unsigned CODE_HI_LSB = 5;
	localparam int unsigned CODE_LO_LSB = 1;
	localparam int unsigned EN_HI_BIT = 4;
	localparam int unsigned EN_LO_BIT = 0;
	// rdi bits sit at 7:5 of the outbound g1 byte
	localparam int unsigned G1_RDI_LSB = 5;
	// status word layout
	localparam int unsigned STAT_INS_BIT = 6;
	localparam int unsigned STAT_CODE_LSB = 8;
	// reset value of every control byte
	localparam logic [7:0] CTRL_RST = 8'h00;
	// defect slots on the defect input vector
	localparam int unsigned DEF_AIS = 0;
	localparam int unsigned DEF_LOP = 1;
	localparam int unsigned DEF_TIM = 2;
	localparam int unsigned DEF_UNEQ = 3;
	localparam int unsigned DEF_LCD = 4;
	localparam int unsigned DEF_PLM = 5;
	localparam int unsigned NUM_DEF = 6;
endpackage : prdi_pkg
`default_nettype wire

/* File: verilog/prdi_g1_ins.sv */
`timescale 1ns/1ps
`default_nettype none
module prdi_g1_ins (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic strobe_i,
	input wire logic [7:0] byte_i,
	input wire logic insert_i,
	input wire logic [prdi_pkg::CODE_W-1:0] code_i,
	output logic [7:0] byte_o,
	output logic valid_o
);
	import prdi_pkg::*;

	// merged byte: code over bits 7:5, rest passes
	wire logic [7:0] merged_w;
	wire logic [7:0] byte_nxt;
	assign merged_w = {code_i, byte_i[G1_RDI_LSB-1:0]};
	assign byte_nxt = insert_i ? merged_w : byte_i;

	// output byte register, loaded on each g1 strobe
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			byte_o <= 8'h00;
			valid_o <= 1'b0;
		end else begin
			valid_o <= strobe_i;
			if (strobe_i) begin
				byte_o <= byte_nxt;
			end
		end
	end

	// low five bits never touched by insertion
	a_g1_low_bits: assert property (
		@(posedge clk_i) disable iff (reset_i)
		strobe_i |=> byte_o[4:0] == $past(byte_i[4:0]))
		else $error("g1 low bits altered");
endmodule : prdi_g1_ins
`default_nettype wire

/* File: verilog/prdi_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module prdi_ctrl (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [prdi_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [prdi_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [prdi_pkg::DAT_W-1:0] wb_dat_i,
	output logic [prdi_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [prdi_pkg::NUM_DEF-1:0] defect_i,
	input wire logic g1_strobe_i,
	input wire logic [7:0] g1_byte_i,
	output logic [7:0] g1_byte_o,
	output logic g1_valid_o,
	output logic rdi_active_o
);
	import prdi_pkg::*;

	// pick a code field from a control byte, high or low half
	function automatic logic [CODE_W-1:0] field_code(
		input logic [7:0] b,
		input logic hi
	);
		field_code = hi ? b[CODE_HI_LSB +: CODE_W] : b[CODE_LO_LSB +: CODE_W];
	endfunction : field_code

	// control byte registers
	logic [7:0] ctrl0_r;
	logic [7:0] ctrl1_r;
	logic [7:0] ctrl2_r;
	// bus answer registers
	logic ack_r;
	logic [DAT_W-1:0] rdat_r;
	// synchroniser stages for the receive defect flags
	logic [NUM_DEF-1:0] sync1_r;
	logic [NUM_DEF-1:0] sync2_r;
	// registered insertion indicator
	logic active_r;

	// two-flop synchroniser, one chain per defect flag
	genvar gi;
	generate
		for (gi = 0; gi < NUM_DEF; gi++) begin : g_sync
			always_ff @(posedge clk_i or posedge reset_i) begin
				if (reset_i) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= defect_i[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// address decode on byte addresses
	wire logic req_w;
	wire logic hit0_w;
	wire logic hit1_w;
	wire logic hit2_w;
	wire logic hits_w;
	wire logic wr_w;
	// ack high blocks a second take of the same request
	assign req_w = wb_cyc_i && wb_stb_i && !ack_r;
	// each register sits at four times its index
	assign hit0_w = wb_adr_i == {IDX_CTRL0, 2'b00};
	assign hit1_w = wb_adr_i == {IDX_CTRL1, 2'b00};
	assign hit2_w = wb_adr_i == {IDX_CTRL2, 2'b00};
	assign hits_w = wb_adr_i == {IDX_STATUS, 2'b00};
	// writes need the low byte lane
	assign wr_w = req_w && wb_we_i && wb_sel_i[0];

	// per-defect code fields
	wire logic [CODE_W-1:0] code_w [NUM_DEF];
	assign code_w[DEF_AIS] = field_code(ctrl0_r, 1'b0);
	assign code_w[DEF_LOP] = field_code(ctrl0_r, 1'b1);
	assign code_w[DEF_TIM] = field_code(ctrl1_r, 1'b1);
	assign code_w[DEF_UNEQ] = field_code(ctrl1_r, 1'b0);
	assign code_w[DEF_LCD] = field_code(ctrl2_r, 1'b1);
	assign code_w[DEF_PLM] = field_code(ctrl2_r, 1'b0);

	// per-defect enable bits
	wire logic [NUM_DEF-1:0] en_w;
	assign en_w[DEF_AIS] = ctrl0_r[EN_LO_BIT];
	assign en_w[DEF_LOP] = ctrl0_r[EN_HI_BIT];
	assign en_w[DEF_TIM] = ctrl1_r[EN_HI_BIT];
	assign en_w[DEF_UNEQ] = ctrl1_r[EN_LO_BIT];
	assign en_w[DEF_LCD] = ctrl2_r[EN_HI_BIT];
	assign en_w[DEF_PLM] = ctrl2_r[EN_LO_BIT];

	// a defect counts only when declared and enabled
	wire logic [NUM_DEF-1:0] armed_w;
	assign armed_w = en_w & sync2_r;

	// fixed priority: ais, lop, uneq, plm, tim, lcd
	wire logic [CODE_W-1:0] sel_code_w;
	wire logic insert_w;
	assign sel_code_w = armed_w[DEF_AIS] ? code_w[DEF_AIS] :
		armed_w[DEF_LOP] ? code_w[DEF_LOP] :
		armed_w[DEF_UNEQ] ? code_w[DEF_UNEQ] :
		armed_w[DEF_PLM] ? code_w[DEF_PLM] :
		armed_w[DEF_TIM] ? code_w[DEF_TIM] :
		code_w[DEF_LCD];
	assign insert_w = |armed_w;

	// status word: synced defects, insert flag, selected code
	wire logic [DAT_W-1:0] stat_w;
	assign stat_w = {{(DAT_W-STAT_CODE_LSB-CODE_W){1'b0}}, sel_code_w,
		1'b0, insert_w, sync2_r};

	// read mux; unmapped addresses read zero
	wire logic [DAT_W-1:0] rmux_w;
	assign rmux_w = hit0_w ? {24'h000000, ctrl0_r} :
		hit1_w ? {24'h000000, ctrl1_r} :
		hit2_w ? {24'h000000, ctrl2_r} :
		hits_w ? stat_w : 32'h00000000;

	// control byte writes
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl0_r <= CTRL_RST;
			ctrl1_r <= CTRL_RST;
			ctrl2_r <= CTRL_RST;
		end else if (wr_w) begin
			if (hit0_w) begin
				ctrl0_r <= wb_dat_i[7:0];
			end else if (hit1_w) begin
				ctrl1_r <= wb_dat_i[7:0];
			end else if (hit2_w) begin
				ctrl2_r <= wb_dat_i[7:0];
			end
		end
	end

	// one-cycle ack with registered read data
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h00000000;
		end else begin
			ack_r <= req_w;
			if (req_w && !wb_we_i) begin
				rdat_r <= rmux_w;
			end
		end
	end

	// insertion indicator register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			active_r <= 1'b0;
		end else begin
			active_r <= insert_w;
		end
	end

	// outputs straight from their registers
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign rdi_active_o = active_r;

	// g1 byte rewrite stage
	prdi_g1_ins u_g1 (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.strobe_i(g1_strobe_i),
		.byte_i(g1_byte_i),
		.insert_i(insert_w),
		.code_i(sel_code_w),
		.byte_o(g1_byte_o),
		.valid_o(g1_valid_o)
	);

	// checks on the merged output, the bus, the control bytes, the sync and the status word
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// armed ais always wins the g1 code
	a_ais_code_out: assert property (
		(g1_strobe_i && armed_w[DEF_AIS])
		|=> g1_byte_o[7:5] == $past(code_w[DEF_AIS]))
		else $error("ais code not inserted");

	// declared but disabled ais leaves g1 untouched
	a_ais_enable_gate: assert property (
		(g1_strobe_i && sync2_r[DEF_AIS] && !ctrl0_r[EN_LO_BIT]
		&& (armed_w & 6'h3e) == 6'h00)
		|=> g1_byte_o == $past(g1_byte_i))
		else $error("ais inserted while disabled");

	// lone armed tim puts its own code out
	a_tim_code_out: assert property (
		(g1_strobe_i && armed_w == 6'h04)
		|=> g1_byte_o[7:5] == $past(code_w[DEF_TIM]))
		else $error("tim code not inserted");

	// declared but disabled tim leaves g1 untouched
	a_tim_enable_gate: assert property (
		(g1_strobe_i && sync2_r[DEF_TIM] && !ctrl1_r[EN_HI_BIT]
		&& (armed_w & 6'h3b) == 6'h00)
		|=> g1_byte_o == $past(g1_byte_i))
		else $error("tim inserted while disabled");

	// lone armed lcd puts its own code out
	a_lcd_code_out: assert property (
		(g1_strobe_i && armed_w == 6'h10)
		|=> g1_byte_o[7:5] == $past(code_w[DEF_LCD]))
		else $error("lcd code not inserted");

	// declared but disabled lcd leaves g1 untouched
	a_lcd_enable_gate: assert property (
		(g1_strobe_i && sync2_r[DEF_LCD] && !ctrl2_r[EN_HI_BIT]
		&& (armed_w & 6'h2f) == 6'h00)
		|=> g1_byte_o == $past(g1_byte_i))
		else $error("lcd inserted while disabled");

	// lop wins whenever ais is not armed
	a_lop_priority: assert property (
		(g1_strobe_i && armed_w[DEF_LOP] && !armed_w[DEF_AIS])
		|=> g1_byte_o[7:5] == $past(code_w[DEF_LOP]))
		else $error("lop code not inserted");

	// lone armed uneq puts its own code out
	a_uneq_code_out: assert property (
		(g1_strobe_i && armed_w == 6'h08)
		|=> g1_byte_o[7:5] == $past(code_w[DEF_UNEQ]))
		else $error("uneq code not inserted");

	// lone armed plm puts its own code out
	a_plm_code_out: assert property (
		(g1_strobe_i && armed_w == 6'h20)
		|=> g1_byte_o[7:5] == $past(code_w[DEF_PLM]))
		else $error("plm code not inserted");

	// nothing armed means the byte passes whole
	a_idle_passthru: assert property (
		(g1_strobe_i && armed_w == 6'h00) |=> g1_byte_o == $past(g1_byte_i))
		else $error("g1 altered with no armed defect");

	// every taken request gets one ack pulse
	a_bus_answer: assert property (
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("wishbone ack not one cycle");

	// defect flags reach the decision two edges late
	a_sync_latency: assert property (
		sync2_r == $past(defect_i, 2))
		else $error("defect sync latency wrong");

	// a taken write to byte 0 lands at that edge
	a_ctrl0_write: assert property (
		(wr_w && hit0_w) |=> ctrl0_r == $past(wb_dat_i[7:0]))
		else $error("control byte 0 write lost");

	// a taken write to byte 1 lands at that edge
	a_ctrl1_write: assert property (
		(wr_w && hit1_w) |=> ctrl1_r == $past(wb_dat_i[7:0]))
		else $error("control byte 1 write lost");

	// a taken write to byte 2 lands at that edge
	a_ctrl2_write: assert property (
		(wr_w && hit2_w) |=> ctrl2_r == $past(wb_dat_i[7:0]))
		else $error("control byte 2 write lost");

	// status read shows insert flag and synced defects
	a_status_insert: assert property (
		(req_w && !wb_we_i && hits_w)
		|=> wb_dat_o[STAT_INS_BIT:0] == $past({insert_w, sync2_r}))
		else $error("status insert flag wrong");

	// status code field carries the chosen code
	a_status_code: assert property (
		(req_w && !wb_we_i && hits_w && insert_w)
		|=> wb_dat_o[STAT_CODE_LSB +: CODE_W] == $past(sel_code_w))
		else $error("status code field wrong");

	// insert indicator trails the decision by one edge
	a_active_follow: assert property (
		rdi_active_o == $past(insert_w))
		else $error("rdi active indicator wrong");

	// each g1 strobe gives exactly one valid pulse
	a_valid_pulse: assert property (
		g1_valid_o == $past(g1_strobe_i))
		else $error("g1 valid not one pulse");

	// unmapped reads answer zero
	a_unmapped_zero: assert property (
		(req_w && !wb_we_i && !(hit0_w || hit1_w || hit2_w || hits_w))
		|=> wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");

	// cover points for the main scenarios
	c_ais_insert: cover property (
		g1_strobe_i && armed_w[DEF_AIS] ##1 g1_valid_o);
	c_multi_defect: cover property (
		g1_strobe_i && armed_w[DEF_AIS] && armed_w[DEF_TIM]);
	c_ctrl_write: cover property (wr_w && hit1_w ##1 wb_ack_o);
	c_status_read: cover property (req_w && !wb_we_i && hits_w);
endmodule : prdi_ctrl
`default_nettype wire

/* File: tb/prdi_defect_src.sv */
`timescale 1ns/1ps
`default_nettype none
// stands in for the receive path processor's defect flags
module prdi_defect_src (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [5:0] want_i,
	output logic [5:0] defect_o
);
	// flags follow the requested set one edge later
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			defect_o <= 6'h00;
		end else begin
			defect_o <= want_i;
		end
	end
endmodule : prdi_defect_src
`default_nettype wire

/* File: tb/tb_path_rdi_auto_insert_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_path_rdi_auto_insert_ctrl;
	import prdi_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [ADR_W-1:0] adr = '0;
	logic [SEL_W-1:0] sel = '0;
	logic [DAT_W-1:0] wdat = '0, rdat, dat_o;
	logic g1_stb = 1'b0, g1_vld, act;
	logic [7:0] g1_in = 8'h00, g1_out;
	logic [5:0] want = 6'h00, defect;
	int n_fail = 0, n_tests = 0, cyc_n = 0;
	int m[3]; // model of the three control bytes
	initial forever #12.5 clk_i = ~clk_i;
	prdi_defect_src rx (.clk_i(clk_i), .reset_i(reset_i), .want_i(want),
		.defect_o(defect));
	prdi_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.defect_i(defect), .g1_strobe_i(g1_stb), .g1_byte_i(g1_in),
		.g1_byte_o(g1_out), .g1_valid_o(g1_vld), .rdi_active_o(act));
	// verdict and end of run
	task automatic conclude();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	// one comparison
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// classic wishbone cycle, entered right after an edge
	task automatic bus(input logic w, input logic [13:0] a,
		input logic [3:0] s, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	// inserted code by fixed priority, -1 when none
	function automatic int pick(int d);
		int ord[6] = '{0, 1, 3, 5, 2, 4};
		int nib;
		foreach (ord[i]) begin
			nib = m[ord[i] / 2] & 15;
			if (ord[i] inside {1, 2, 4}) nib = m[ord[i] / 2] >> 4;
			if (d[ord[i]] && nib[0]) return nib >> 1;
		end
		return -1;
	endfunction : pick
	// one g1 byte through the path
	task automatic g1(input logic [7:0] b);
		int c;
		logic [31:0] st, ex;
		c = pick(want);
		g1_stb <= 1'b1;
		g1_in <= b;
		@(posedge clk_i);
		g1_stb <= 1'b0;
		#1;
		chk("valid", 1, g1_vld);
		chk("g1", (c < 0) ? b : {c[2:0], b[4:0]}, g1_out);
		chk("active", c >= 0, act);
		@(posedge clk_i);
		bus(0, {IDX_STATUS, 2'b00}, 4'h1, 0);
		// code field is only defined while a code is inserted
		st = (c < 0) ? (rdat & 32'hfffff8ff) : rdat;
		ex = {21'h0, (c < 0) ? 3'h0 : c[2:0], 1'b0, c >= 0, want};
		chk("status", ex, st);
	endtask : g1
	// cycle ceiling
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 40000) begin
			n_fail++;
			conclude();
		end
	end
	// main sequence
	initial begin
		logic [31:0] d;
		void'($urandom(13848));
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		// a write without sel[0], then a read of the reset values
		for (int r = 0; r < 3; r++) begin
			bus(1, {IDX_CTRL0 - r[11:0], 2'b00}, 4'he, 32'hff);
			bus(0, {IDX_CTRL0 - r[11:0], 2'b00}, 4'h1, 0);
			chk("ctrl reset", {24'h0, CTRL_RST}, rdat);
		end
		bus(0, 14'h0000, 4'h1, 0);
		chk("unmapped", 0, rdat);
		// random codes, enables and defect sets
		for (int n = 0; n < 250; n++) begin
			for (int r = 0; r < 3; r++) begin
				d = $urandom;
				m[r] = d & 255;
				bus(1, {IDX_CTRL0 - r[11:0], 2'b00}, 4'h1, d);
				bus(0, {IDX_CTRL0 - r[11:0], 2'b00}, 4'h1, 0);
				chk("ctrl", m[r], rdat);
			end
			want <= 6'($urandom);
			repeat (6) @(posedge clk_i);
			g1(8'($urandom));
		end
		conclude();
	end
endmodule : tb_path_rdi_auto_insert_ctrl
`default_nettype wire
